// >>> pkg/twi_status_pkg.sv
package twi_status_pkg;

   // ----------------------------------------------------------------
   // register byte addresses
   // ----------------------------------------------------------------
   localparam logic [31:0] ADDR_STATUS       = 32'hfff8_4020;
   localparam logic [31:0] ADDR_IRQ_SET      = 32'hfff8_4024;
   localparam logic [31:0] ADDR_IRQ_CLEAR    = 32'hfff8_4028;
   localparam logic [31:0] ADDR_IRQ_VIEW     = 32'hfff8_402c;
   localparam logic [31:0] ADDR_RX_BYTE      = 32'hfff8_4030;
   localparam logic [31:0] ADDR_TX_BYTE      = 32'hfff8_4034;

   // ----------------------------------------------------------------
   // status, enable, disable and mask bit positions
   // ----------------------------------------------------------------
   localparam int BIT_TRANSFER_COMPLETE  = 0;
   localparam int BIT_RECEIVE_READY   = 1;
   localparam int BIT_TRANSMIT_READY   = 2;
   localparam int BIT_SVREAD  = 3;
   localparam int BIT_SLAVE_ACCESS_MATCHED   = 4;
   localparam int BIT_GENERAL_CALL_SEEN    = 5;
   localparam int BIT_OVERRUN_ERROR    = 6;
   localparam int BIT_NACK    = 8;
   localparam int BIT_ARBITRATION_LOST  = 9;
   localparam int BIT_CLOCK_WAIT_FLAG   = 10;
   localparam int BIT_END_OF_SLAVE_ACCESS  = 11;

   // bits that exist in the enable, disable and mask registers
   localparam logic [31:0] IRQ_BITS_VALID    = 32'h0000_0f77;

   // ----------------------------------------------------------------
   // values after reset
   // ----------------------------------------------------------------
   localparam logic [31:0] MASK_RST          = 32'h0000_0000;
   localparam logic [7:0]  TX_BYTE_RST       = 8'h00;
   localparam logic [7:0]  RX_BYTE_RST       = 8'h00;
   localparam logic [31:0] RDATA_RST         = 32'h0000_0000;
   localparam logic        TRANSFER_COMPLETE_RST        = 1'b1;
   localparam logic        TRANSMIT_READY_RST         = 1'b0;
   localparam logic        SCL_IDLE_LEVEL    = 1'b1;

   // ----------------------------------------------------------------
   // bus answer states
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      BUS_IDLE   = 2'b01,
      BUS_ANSWER = 2'b10
   } bus_state_t;

endpackage

// >>> rtl/twi_pin_sync.sv
`timescale 1ns/100ps
module twi_pin_sync
   import twi_status_pkg::*;
#(
   parameter int                WIDTH     = 1,
   parameter logic [WIDTH-1:0]  RST_LEVEL = '1
) (
   // clock and reset
   input  wire logic             sys_clk,
   input  wire logic             srst,
   // pin side and clock side
   input  wire logic [WIDTH-1:0] pin_async,
   output logic      [WIDTH-1:0] pin_synced
);

   typedef struct packed {
      logic [WIDTH-1:0] meta;
      logic [WIDTH-1:0] stable;
   } sync_state_t;

   sync_state_t st_reg;
   sync_state_t st_next;

   // the first stage feeds only the second; nothing else looks at it
   always_comb begin
      st_next        = st_reg;
      st_next.meta   = pin_async;
      st_next.stable = st_reg.meta;
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         st_reg <= '{meta: RST_LEVEL, stable: RST_LEVEL};
      end else begin
         st_reg <= st_next;
      end
   end

   assign pin_synced = st_reg.stable;

endmodule // twi_pin_sync

// >>> rtl/twi_status_irq.sv
// Register access over Avalon-MM was decided locally.
`timescale 1ns/100ps
// Function
// - master losing arbitration sets arbitration-lost and transfer-complete together
// - arbitration-lost only in master mode, cleared by status read, zero means won
// - slave stretches clock while transmit not refilled or receive not emptied
// - clock-wait flag is hardware only and zero when clock not stretched
// - end-of-slave-access sets when slave access falls, zero during access
// - status read clears end-of-slave-access
// - writing one to enable register enables that source, zero no effect
// - writing one to disable register disables that source, zero no effect
// - mask register reads enabled sources, all disabled after reset
// - end-of-access bit 11, clock-wait 10, arbitration-lost 9, not-ack 8
// - complete 0, rx 1, tx 2, slave 4, general call 5, overrun 6
// - receive holding register shows last byte received on bits 7..0
// - transmit holding register takes next byte in low eight bits, resets zero
// - receive-ready means new byte since last holding read, read clears it
// - writing transmit holding register clears transmit-ready
// - slave access rises on address match, stays until not-ack or stop
module twi_status_irq
   import twi_status_pkg::*;
(
   // clock and reset
   input  wire logic        sys_clk,
   input  wire logic        srst,
   // avalon-mm slave
   input  wire logic [31:0] address,
   input  wire logic        read,
   input  wire logic        write,
   input  wire logic [31:0] writedata,
   input  wire logic [3:0]  byteenable,
   output logic      [31:0] readdata,
   output logic             waitrequest,
   // interrupt
   output logic             irq,
   // controller events and levels, same clock
   input  wire logic        master_mode,
   input  wire logic        slave_mode,
   input  wire logic        master_enable_evt,
   input  wire logic        transfer_complete_set,
   input  wire logic        transfer_complete_clr,
   input  wire logic        arb_lost_evt,
   input  wire logic        nack_evt,
   input  wire logic        stop_evt,
   input  wire logic        addr_match_evt,
   input  wire logic        slave_read_dir,
   input  wire logic        general_call_evt,
   input  wire logic        byte_boundary,
   // shifter side data
   input  wire logic        rx_byte_valid,
   input  wire logic [7:0]  rx_byte,
   input  wire logic        tx_byte_taken,
   output logic      [7:0]  outgoing_byte_value,
   output logic             tx_byte_pending,
   // serial clock pin, open drain
   input  wire logic        scl_i,
   output logic             scl_o,
   output logic             scl_oe
);

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   typedef struct packed {
      bus_state_t  bus;
      logic        waitreq;
      logic [31:0] rdata;
      logic        transfer_complete;
      logic        receive_ready;
      logic        transmit_ready;
      logic        slave_access_matched;
      logic        general_call_seen;
      logic        overrun_error;
      logic        nack;
      logic        arbitration_lost;
      logic        end_of_slave_access;
      logic        stretch;
      logic        pending;
      logic        scl_last;
      logic        scl_level;
      logic [7:0]  rhr;
      logic [7:0]  thr;
      logic [31:0] mask;
      logic        irq;
   } state_t;

   localparam state_t RESET_STATE = '{
      bus:       BUS_IDLE,
      waitreq:   1'b1,
      rdata:     RDATA_RST,
      transfer_complete:    TRANSFER_COMPLETE_RST,
      receive_ready:     1'b0,
      transmit_ready:     TRANSMIT_READY_RST,
      slave_access_matched:     1'b0,
      general_call_seen:      1'b0,
      overrun_error:      1'b0,
      nack:      1'b0,
      arbitration_lost:    1'b0,
      end_of_slave_access:    1'b0,
      stretch:   1'b0,
      pending:   1'b0,
      scl_last:  SCL_IDLE_LEVEL,
      scl_level: 1'b0,
      rhr:       RX_BYTE_RST,
      thr:       TX_BYTE_RST,
      mask:      MASK_RST,
      irq:       1'b0
   };

   state_t st_reg;
   state_t st_next;

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   // status word layout, shared by the bus read and the interrupt
   function automatic logic [31:0] status_word(input state_t s, input logic svr);
      logic [31:0] w;
      w              = 32'h0000_0000;
      w[BIT_TRANSFER_COMPLETE]  = s.transfer_complete;
      w[BIT_RECEIVE_READY]   = s.receive_ready;
      w[BIT_TRANSMIT_READY]   = s.transmit_ready;
      w[BIT_SVREAD]  = svr;
      w[BIT_SLAVE_ACCESS_MATCHED]   = s.slave_access_matched;
      w[BIT_GENERAL_CALL_SEEN]    = s.general_call_seen;
      w[BIT_OVERRUN_ERROR]    = s.overrun_error;
      w[BIT_NACK]    = s.nack;
      w[BIT_ARBITRATION_LOST]  = s.arbitration_lost;
      w[BIT_CLOCK_WAIT_FLAG]   = s.stretch;
      w[BIT_END_OF_SLAVE_ACCESS]  = s.end_of_slave_access;
      return w;
   endfunction

   function automatic logic [31:0] lane_mask(input logic [3:0] be);
      return {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
   endfunction

   // ----------------------------------------------------------------
   // serial clock sampling
   // ----------------------------------------------------------------
   logic scl_sync;

   twi_pin_sync #(
      .WIDTH     (1),
      .RST_LEVEL (SCL_IDLE_LEVEL)
   ) u_scl_sync (
      .sys_clk    (sys_clk),
      .srst       (srst),
      .pin_async  (scl_i),
      .pin_synced (scl_sync)
   );

   // ----------------------------------------------------------------
   // access decode
   // ----------------------------------------------------------------
   logic        accept;
   logic        acc_rd;
   logic        acc_wr;
   logic [31:0] wmask;
   logic        rd_status;
   logic        rd_rhr;
   logic        wr_set;
   logic        wr_clr;
   logic        wr_thr;
   logic        arb_now;
   logic        scl_fall;
   logic        buf_wait;

   // a transfer completes on the edge where waitrequest is seen low
   assign accept    = (st_reg.bus == BUS_ANSWER);
   assign acc_rd    = accept & read;
   assign acc_wr    = accept & write;
   assign wmask     = lane_mask(byteenable);
   assign rd_status = acc_rd & (address == ADDR_STATUS);
   assign rd_rhr    = acc_rd & (address == ADDR_RX_BYTE);
   assign wr_set    = acc_wr & (address == ADDR_IRQ_SET);
   assign wr_clr    = acc_wr & (address == ADDR_IRQ_CLEAR);
   assign wr_thr    = acc_wr & (address == ADDR_TX_BYTE) & byteenable[0];
   assign arb_now   = arb_lost_evt & master_mode;
   assign scl_fall  = st_reg.scl_last & ~scl_sync;
   // transmit side waits for a refill, receive side for an empty holding
   assign buf_wait  = slave_read_dir ? st_reg.transmit_ready : st_reg.receive_ready;

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      st_next = st_reg;

      // two-cycle answer: readdata is loaded while waitrequest drops
      case (st_reg.bus)
         BUS_IDLE: begin
            if (read || write) begin
               st_next.bus     = BUS_ANSWER;
               st_next.waitreq = 1'b0;
            end
         end
         BUS_ANSWER: begin
            st_next.bus     = BUS_IDLE;
            st_next.waitreq = 1'b1;
         end
         default: begin
            st_next.bus     = BUS_IDLE;
            st_next.waitreq = 1'b1;
         end
      endcase

      // flags: a set in the cycle of a clear always wins
      st_next.transfer_complete = (st_reg.transfer_complete & ~transfer_complete_clr) | transfer_complete_set | arb_now;
      st_next.arbitration_lost = (st_reg.arbitration_lost & ~rd_status) | arb_now;
      st_next.nack   = (st_reg.nack & ~rd_status) | nack_evt;
      st_next.general_call_seen   = (st_reg.general_call_seen & ~rd_status) | general_call_evt;
      // overrun only clears by a status read once the frame has completed
      st_next.overrun_error   = (st_reg.overrun_error & ~(rd_status & st_reg.transfer_complete)) | (rx_byte_valid & st_reg.receive_ready);
      st_next.receive_ready  = (st_reg.receive_ready & ~rd_rhr) | rx_byte_valid;
      st_next.transmit_ready  = (st_reg.transmit_ready & ~wr_thr) | tx_byte_taken | nack_evt | master_enable_evt;
      st_next.slave_access_matched  = (st_reg.slave_access_matched & ~(nack_evt | stop_evt)) | addr_match_evt;
      // end of access sets on the falling edge of the access flag only
      st_next.end_of_slave_access = st_next.slave_access_matched ? 1'b0 : (st_reg.slave_access_matched | (st_reg.end_of_slave_access & ~rd_status));

      // holding registers
      if (rx_byte_valid) begin
         st_next.rhr = rx_byte;
      end
      if (wr_thr) begin
         st_next.thr = writedata[7:0];
      end

      // enable and disable share one mask; a zero bit leaves it alone
      if (wr_set) begin
         st_next.mask = st_reg.mask | (writedata & wmask & IRQ_BITS_VALID);
      end
      if (wr_clr) begin
         st_next.mask = st_reg.mask & ~(writedata & wmask & IRQ_BITS_VALID);
      end

      // clock stretching on the first low phase after a character
      st_next.scl_last  = scl_sync;
      st_next.scl_level = 1'b0;
      if (!slave_mode || !st_reg.slave_access_matched) begin
         st_next.pending = 1'b0;
         st_next.stretch = 1'b0;
      end else begin
         if (st_reg.stretch) begin
            st_next.stretch = buf_wait;
         end else if (st_reg.pending && scl_fall) begin
            st_next.pending = 1'b0;
            st_next.stretch = buf_wait;
         end
         if (byte_boundary) begin
            st_next.pending = 1'b1;
         end
      end

      // read value taken from the state that stands at the answer edge
      if (st_reg.bus == BUS_IDLE && read) begin
         case (address)
            ADDR_STATUS:   st_next.rdata = status_word(st_next, slave_read_dir);
            ADDR_IRQ_VIEW: st_next.rdata = st_next.mask;
            ADDR_RX_BYTE:  st_next.rdata = {24'h000000, st_next.rhr};
            ADDR_TX_BYTE:  st_next.rdata = {24'h000000, st_next.thr};
            default:       st_next.rdata = RDATA_RST;
         endcase
      end

      st_next.irq = |(status_word(st_next, 1'b0) & st_next.mask);
   end

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         st_reg <= RESET_STATE;
      end else begin
         st_reg <= st_next;
      end
   end

   // outputs straight from the state flops
   assign readdata            = st_reg.rdata;
   assign waitrequest         = st_reg.waitreq;
   assign irq                 = st_reg.irq;
   assign outgoing_byte_value = st_reg.thr;
   assign tx_byte_pending     = ~st_reg.transmit_ready;
   assign scl_o               = st_reg.scl_level;
   assign scl_oe              = st_reg.stretch;

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (srst);

   sequence bus_request_s;
      st_reg.bus == BUS_IDLE && (read || write);
   endsequence

   sequence bus_answer_s;
      !waitrequest ##1 waitrequest;
   endsequence

   sequence set_write_s;
      accept && write && address == ADDR_IRQ_SET && byteenable == 4'hf;
   endsequence

   sequence clr_write_s;
      accept && write && address == ADDR_IRQ_CLEAR && byteenable == 4'hf;
   endsequence

   bus_answer_a: assert property (bus_request_s |=> bus_answer_s)
      else $error("bus answer not in two cycles");
   arb_with_complete_a: assert property (arb_lost_evt && master_mode |=> st_reg.arbitration_lost && st_reg.transfer_complete)
      else $error("arbitration lost without transfer complete");
   arb_master_only_a: assert property ($rose(st_reg.arbitration_lost) |-> $past(arb_lost_evt && master_mode))
      else $error("arbitration lost set outside master mode");
   stretch_holds_a: assert property (st_reg.stretch && slave_mode && st_reg.slave_access_matched && buf_wait |=> scl_oe)
      else $error("clock released while buffer still waiting");
   stretch_release_a: assert property ($fell(scl_oe) |-> $past(!buf_wait || !slave_mode || !st_reg.slave_access_matched))
      else $error("clock wait dropped without cause");
   eos_on_fall_a: assert property ($fell(st_reg.slave_access_matched) |-> st_reg.end_of_slave_access)
      else $error("end of access missing after access fall");
   eos_in_access_a: assert property (st_reg.slave_access_matched |-> !st_reg.end_of_slave_access)
      else $error("end of access set during access");
   eos_read_clear_a: assert property (rd_status && !st_reg.slave_access_matched |=> !st_reg.end_of_slave_access)
      else $error("status read left end of access set");
   enable_set_a: assert property (set_write_s |=> (st_reg.mask & ($past(writedata) & IRQ_BITS_VALID))
                                  == ($past(writedata) & IRQ_BITS_VALID))
      else $error("enable write did not set mask bits");
   enable_keep_a: assert property (set_write_s |=> (st_reg.mask & ~$past(writedata))
                                   == ($past(st_reg.mask) & ~$past(writedata)))
      else $error("enable write changed other mask bits");
   disable_clr_a: assert property (clr_write_s |=> (st_reg.mask & $past(writedata)) == 32'h0000_0000)
      else $error("disable write did not clear mask bits");
   mask_reset_a: assert property ($fell(srst) |-> st_reg.mask == MASK_RST && !irq)
      else $error("mask not cleared by reset");
   mask_view_a: assert property (accept && read && address == ADDR_IRQ_VIEW |-> readdata == st_reg.mask)
      else $error("mask read value wrong");
   rx_capture_a: assert property (rx_byte_valid |=> st_reg.rhr == $past(rx_byte) && st_reg.receive_ready)
      else $error("received byte not captured");
   rx_clear_a: assert property (rd_rhr && !rx_byte_valid |=> !st_reg.receive_ready)
      else $error("holding read left receive ready set");
   tx_clear_a: assert property (wr_thr && !tx_byte_taken && !nack_evt && !master_enable_evt
                                |=> !st_reg.transmit_ready && outgoing_byte_value == $past(writedata[7:0]))
      else $error("holding write did not clear transmit ready");
   access_hold_a: assert property (st_reg.slave_access_matched && !nack_evt && !stop_evt |=> st_reg.slave_access_matched)
      else $error("slave access dropped without stop or nack");
   access_rise_a: assert property (addr_match_evt |=> st_reg.slave_access_matched)
      else $error("slave access not set on match");
   irq_level_a: assert property (irq == |(status_word(st_reg, 1'b0) & st_reg.mask))
      else $error("interrupt level disagrees with flags");

endmodule // twi_status_irq

// >>> verif/twi_far_side.sv
`timescale 1ns/100ps
module twi_far_side #(
   parameter int HALF_NS = 40
) (
   // frame control from the bench
   input  wire logic frame_on,
   // device side of the clock wire
   input  wire logic scl_o,
   input  wire logic scl_oe,
   // resolved clock wire
   output logic      scl_line
);
   logic far_low = 1'b0;

   // wired-and with a pull-up: the wire idles high whenever nobody pulls it
   assign scl_line = ~far_low & (scl_oe ? scl_o : 1'b1);

   // --------------------------------------------------------------
   // remote master clock
   // --------------------------------------------------------------
   // runs only inside a frame; a low held by the device delays the high phase
   initial begin
      #13;
      forever begin
         if (!frame_on) begin
            far_low = 1'b0;
            wait (frame_on);
         end
         #HALF_NS;
         far_low = ~far_low;
         if (!far_low) wait (scl_line);
      end
   end
endmodule // twi_far_side

// >>> verif/tb.sv
`timescale 1ns/100ps
module tb;
   import twi_status_pkg::*;
   typedef struct {logic [31:0] v; logic [31:0] m;} exp_t;
   logic        sys_clk = 1'b0;
   logic        srst = 1'b1;
   logic [31:0] address = '0;
   logic [31:0] writedata = '0;
   logic        read = 1'b0;
   logic        write = 1'b0;
   logic [3:0]  be = 4'hf;
   logic [10:0] ev = '0;
   logic        master_mode = 1'b0;
   logic        slave_mode = 1'b0;
   logic        read_dir = 1'b0;
   logic        frame_on = 1'b0;
   logic [7:0]  rx_byte = '0;
   logic [31:0] readdata, r, k;
   logic [7:0]  outgoing_byte_value;
   logic        waitrequest, irq, tx_byte_pending, scl_o, scl_oe, scl_line;
   exp_t        exp_q[$];
   exp_t        e;
   int          failures = 0;
   int          total_checks = 0;
   int          n;

   always #2 sys_clk = ~sys_clk;

   twi_status_irq i_dut (.sys_clk(sys_clk), .srst(srst), .address(address), .read(read),
      .write(write), .writedata(writedata), .byteenable(be), .readdata(readdata),
      .waitrequest(waitrequest), .irq(irq), .master_mode(master_mode), .slave_mode(slave_mode),
      .master_enable_evt(ev[0]), .transfer_complete_set(ev[1]), .transfer_complete_clr(ev[2]),
      .arb_lost_evt(ev[3]), .nack_evt(ev[4]), .stop_evt(ev[5]), .addr_match_evt(ev[6]),
      .slave_read_dir(read_dir), .general_call_evt(ev[7]), .byte_boundary(ev[8]),
      .rx_byte_valid(ev[9]), .rx_byte(rx_byte), .tx_byte_taken(ev[10]),
      .outgoing_byte_value(outgoing_byte_value), .tx_byte_pending(tx_byte_pending),
      .scl_i(scl_line), .scl_o(scl_o), .scl_oe(scl_oe));

   twi_far_side i_far (.frame_on(frame_on), .scl_o(scl_o), .scl_oe(scl_oe), .scl_line(scl_line));

   // --------------------------------------------------------------
   // shared tasks
   // --------------------------------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         failures++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // one avalon cycle; held until waitrequest is sampled low
   task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
      int c;
      @(posedge sys_clk);
      read <= ~w;
      write <= w;
      address <= a;
      writedata <= d;
      c = 0;
      do begin
         @(posedge sys_clk);
         c++;
      end while (waitrequest !== 1'b0 && c < 100);
      if (c >= 100) failures++;
      read <= 1'b0;
      write <= 1'b0;
   endtask

   // note the expectation, then read; only masked bits are compared
   task automatic rd(input logic [31:0] a, input logic [31:0] v, input logic [31:0] m);
      exp_q.push_back('{v, m});
      bus(1'b0, a, 32'h0);
   endtask

   task automatic pulse(input int b);
      @(posedge sys_clk);
      ev[b] <= 1'b1;
      @(posedge sys_clk);
      ev[b] <= 1'b0;
   endtask

   task automatic settle(input int c);
      repeat (c) @(posedge sys_clk);
   endtask

   task automatic summarize;
      $display("checks %0d failures %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask

   // read data are taken at the accept edge and matched against the oldest note
   always @(posedge sys_clk) begin
      if (read && waitrequest === 1'b0) begin
         if (exp_q.size() == 0) chk(32'hdead_beef, 32'h0);
         else begin
            e = exp_q.pop_front();
            chk(readdata & e.m, e.v & e.m);
         end
      end
   end

   // watchdog: the whole sequence needs a few hundred cycles
   initial begin
      repeat (20000) @(posedge sys_clk);
      failures++;
      summarize();
   end

   // --------------------------------------------------------------
   // main sequence
   // --------------------------------------------------------------
   initial begin
      void'($urandom(32'haf21));
      repeat (6) @(posedge sys_clk);
      srst <= 1'b0;
      rd(ADDR_IRQ_VIEW, 32'h0, '1);
      rd(ADDR_TX_BYTE, 32'h0, '1);
      rd(ADDR_RX_BYTE, 32'h0, '1);
      rd(ADDR_STATUS, 32'h1, '1);
      rd(32'hfff8_4040, 32'h0, '1);
      // enable and disable through write-one registers
      r = $urandom() & 32'h0000_0f77;
      bus(1'b1, ADDR_IRQ_SET, r);
      rd(ADDR_IRQ_VIEW, r, '1);
      bus(1'b1, ADDR_IRQ_SET, 32'h0);
      rd(ADDR_IRQ_VIEW, r, '1);
      k = $urandom();
      bus(1'b1, ADDR_IRQ_CLEAR, k);
      rd(ADDR_IRQ_VIEW, r & ~k, '1);
      bus(1'b1, ADDR_IRQ_SET, '1);
      rd(ADDR_IRQ_VIEW, 32'h0000_0f77, '1);
      bus(1'b1, ADDR_IRQ_CLEAR, '1);
      rd(ADDR_IRQ_VIEW, 32'h0, '1);
      // arbitration loss with interrupt raise, mask and clear
      @(posedge sys_clk) master_mode <= 1'b1;
      bus(1'b1, ADDR_IRQ_SET, 32'h200);
      pulse(2);
      pulse(3);
      settle(3);
      chk(irq, 1'b1);
      rd(ADDR_STATUS, 32'h201, 32'h201);
      rd(ADDR_STATUS, 32'h0, 32'h200);
      settle(3);
      chk(irq, 1'b0);
      pulse(3);
      bus(1'b1, ADDR_IRQ_CLEAR, 32'h200);
      settle(3);
      chk(irq, 1'b0);
      bus(1'b1, ADDR_IRQ_SET, 32'h200);
      settle(3);
      chk(irq, 1'b1);
      rd(ADDR_STATUS, 32'h200, 32'h200);
      @(posedge sys_clk) master_mode <= 1'b0;
      pulse(3);
      rd(ADDR_STATUS, 32'h0, 32'h200);
      // not-ack and general call flags, cleared by a status read
      pulse(4);
      rd(ADDR_STATUS, 32'h100, 32'h100);
      pulse(7);
      rd(ADDR_STATUS, 32'h020, 32'h120);
      // transfer complete cleared and set again by the controller
      pulse(2);
      rd(ADDR_STATUS, 32'h0, 32'h1);
      pulse(1);
      rd(ADDR_STATUS, 32'h1, 32'h1);
      // receive path and overrun
      @(posedge sys_clk) rx_byte <= 8'($urandom());
      pulse(9);
      rd(ADDR_STATUS, 32'h2, 32'h42);
      rd(ADDR_RX_BYTE, {24'h0, rx_byte}, '1);
      rd(ADDR_STATUS, 32'h0, 32'h2);
      pulse(9);
      pulse(9);
      rd(ADDR_STATUS, 32'h42, 32'h42);
      rd(ADDR_RX_BYTE, {24'h0, rx_byte}, '1);
      // transmit holding and its ready flag
      pulse(0);
      settle(2);
      chk(tx_byte_pending, 1'b0);
      r = $urandom();
      bus(1'b1, ADDR_TX_BYTE, r);
      settle(2);
      chk(outgoing_byte_value, r[7:0]);
      chk(tx_byte_pending, 1'b1);
      rd(ADDR_TX_BYTE, {24'h0, r[7:0]}, '1);
      pulse(10);
      settle(2);
      chk(tx_byte_pending, 1'b0);
      // slave access and its end
      @(posedge sys_clk) slave_mode <= 1'b1;
      pulse(6);
      rd(ADDR_STATUS, 32'h10, 32'h810);
      pulse(5);
      rd(ADDR_STATUS, 32'h800, 32'h810);
      rd(ADDR_STATUS, 32'h0, 32'h800);
      // stretch while the received byte is not read
      pulse(6);
      pulse(9);
      pulse(8);
      @(posedge sys_clk) frame_on <= 1'b1;
      n = 0;
      while (scl_oe !== 1'b1 && n < 300) begin
         @(posedge sys_clk);
         n++;
      end
      chk(scl_oe, 1'b1);
      chk(scl_o, 1'b0);
      rd(ADDR_STATUS, 32'h400, 32'h400);
      rd(ADDR_RX_BYTE, {24'h0, rx_byte}, '1);
      settle(4);
      chk(scl_oe, 1'b0);
      rd(ADDR_STATUS, 32'h0, 32'h400);
      // stretch while the transmit holding register waits for a refill
      @(posedge sys_clk) read_dir <= 1'b1;
      pulse(8);
      n = 0;
      while (scl_oe !== 1'b1 && n < 300) begin
         @(posedge sys_clk);
         n++;
      end
      chk(scl_oe, 1'b1);
      rd(ADDR_STATUS, 32'h40c, 32'h40c);
      r = $urandom();
      bus(1'b1, ADDR_TX_BYTE, r);
      settle(4);
      chk(scl_oe, 1'b0);
      chk(tx_byte_pending, 1'b1);
      @(posedge sys_clk) frame_on <= 1'b0;
      pulse(5);
      settle(4);
      summarize();
   end
endmodule // tb
